/* design/qsf_pkg.sv */
// constants and types shared by the quad serial flash pin interface
package qsf_pkg;

   // array organisation
   localparam int ADDR_WIDTH = 21;
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_COUNT = 8192;
   localparam int SECTOR_PAGES = 16;
   localparam int BLOCK32_PAGES = 128;
   localparam int BLOCK64_PAGES = 256;
   localparam int UNIQUE_ID_BITS = 64;
   localparam int CONT_READ_ADDR_BITS = 24;
   localparam int CONT_READ_OVERHEAD_CLOCKS = 8;

   // field positions inside a byte address
   localparam int PAGE_LSB = 8;
   localparam int SECTOR_LSB = 12;
   localparam int BLOCK64_LSB = 16;

   // protection arithmetic
   localparam logic [9:0] SECTOR_COUNT = 10'h200;
   localparam logic [9:0] BLOCK_COUNT = 10'h020;
   localparam logic [9:0] SECTOR_MAX_UNITS = 10'h008;
   localparam logic [9:0] UNIT_ONE = 10'h001;
   localparam logic [2:0] BP_NONE = 3'h0;
   localparam logic [2:0] BP_ALL_BLOCKS = 3'h6;
   localparam logic [2:0] BP_SECTOR_CAP = 3'h5;

   // page program byte limit
   localparam logic [8:0] PROG_LIMIT = 9'h100;
   localparam logic [8:0] PROG_STEP = 9'h001;

   // shift counting
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BITS_SINGLE = 4'h1;
   localparam logic [3:0] BITS_DUAL = 4'h2;
   localparam logic [3:0] BITS_QUAD = 4'h4;

   // values after reset
   localparam logic RESET_OE_N = 1'b1;
   localparam logic RESET_BIT = 1'b0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [3:0] RESET_COUNT = 4'h0;
   localparam logic [8:0] RESET_PROG = 9'h000;

   // lane width selected by the command decoder
   typedef enum logic [1:0]
   {
      LANE_SINGLE = 2'h0,
      LANE_DUAL = 2'h1,
      LANE_QUAD = 2'h2
   } qsf_lane_type;

   // link states
   typedef enum logic [3:0]
   {
      LS_UNARMED = 4'h1,
      LS_IDLE = 4'h2,
      LS_ACTIVE = 4'h4,
      LS_HOLD = 4'h8
   } qsf_link_type;

endpackage

/* design/qsf_sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module qsf_sync2
#(
   parameter int WIDTH = 6
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   import qsf_pkg::*;

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   if (WIDTH < 1)
   begin : g_chk
      $error("qsf_sync2: WIDTH must be at least 1");
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stage1_reg <= {WIDTH{RESET_BIT}};
         stage2_reg <= {WIDTH{RESET_BIT}};
      end
      else
      begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;
endmodule
`default_nettype wire

/* design/qsf_pin_if.sv */
// pin interface of a quad serial flash: selection, hold, lane shifting, protection
//
// Behaviour
// - chip select high: deselected, every data line released to high impedance
// - chip select low selects; bytes shift in and out for the whole selection
// - after power-up nothing is accepted until a chip select falling edge
// - single mode samples serial_in on each serial clock rising edge
// - single mode drives serial_out on each serial clock falling edge
// - dual and quad: lines bidirectional, capture on rise, drive on fall
// - single and dual use lines 0 and 1; quad uses lines 0 to 3
// - quad transfers execute only while quad_enable_bit is set
// - quad disabled: write protect pin is line 2, hold pin is line 3
// - quad enabled: hardware write protect function is disabled
// - write protect low plus protect bits rejects status register writes
// - protect bits make part or all of the array immune to program and erase
// - array is 8192 pages of 256 bytes; one program writes at most 256
// - erase units: 16-page sectors, 128 and 256-page blocks, whole chip
// - continuous read: frame starts with a 24-bit address, no opcode
// - manufacturer and device identification plus 64-bit unique serial number
// - serial clock modes 0 and 3 both work
// - hold while selected tri-states output and ignores inputs; not in quad
`timescale 1ns/1ps
`default_nettype none
module qsf_pin_if
#(
   parameter int ADDR_BITS = qsf_pkg::ADDR_WIDTH,
   parameter logic [7:0] MANUFACTURER_ID = 8'h5C,          // arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h3A15,            // arbitrary value
   parameter logic [63:0] UNIQUE_ID = 64'h0F1E2D3C4B5A6978 // arbitrary value
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic chipSelN,
   input wire logic serialClk,
   input wire logic dataLine0In,
   input wire logic dataLine1In,
   input wire logic dataLine2In,
   input wire logic dataLine3In,
   output logic dataLine0Out,
   output logic dataLine1Out,
   output logic dataLine2Out,
   output logic dataLine3Out,
   output logic dataLine0OeN,
   output logic dataLine1OeN,
   output logic dataLine2OeN,
   output logic dataLine3OeN,
   input wire logic quadEnableBit,
   input wire logic [1:0] statusProtectBits,
   input wire logic [2:0] blockProtectBits,
   input wire logic sectorSelectBit,
   input wire logic topBottomBit,
   input wire qsf_pkg::qsf_lane_type laneMode,
   input wire logic driveOut,
   input wire logic [7:0] txData,
   input wire logic contReadMode,
   input wire logic programPhase,
   input wire logic [qsf_pkg::ADDR_WIDTH-1:0] checkAddr,
   input wire logic [3:0] idByteSel,
   output logic selected,
   output logic frameStart,
   output logic frameEnd,
   output logic holdActive,
   output logic [7:0] rxData,
   output logic rxValid,
   output logic txTake,
   output logic quadRefused,
   output logic statusWriteAllowed,
   output logic addrProtected,
   output logic startsAtAddress,
   output logic programOverflow,
   output logic [7:0] idByte
);
   import qsf_pkg::*;

   if (ADDR_BITS != ADDR_WIDTH)
   begin : g_chk
      $error("qsf_pin_if: address width must match the array size");
   end

   // bits moved per serial clock for a lane mode
   function automatic logic [3:0] laneBits(input qsf_lane_type m);
      unique case (m)
         LANE_DUAL: laneBits = BITS_DUAL;
         LANE_QUAD: laneBits = BITS_QUAD;
         default: laneBits = BITS_SINGLE;
      endcase
   endfunction

   // true when the address falls inside the protected region
   function automatic logic protFn(input logic [ADDR_WIDTH-1:0] a, input logic [2:0] bp,
                                   input logic sectorMode, input logic bottom);
      logic [9:0] unit;
      logic [9:0] total;
      logic [9:0] n;
      logic hit;
      if (sectorMode)
      begin
         unit = {1'b0, a[ADDR_WIDTH-1:SECTOR_LSB]};
         total = SECTOR_COUNT;
         n = (bp >= BP_SECTOR_CAP) ? SECTOR_MAX_UNITS : (UNIT_ONE << (bp - 3'h1));
      end
      else
      begin
         unit = {5'h00, a[ADDR_WIDTH-1:BLOCK64_LSB]};
         total = BLOCK_COUNT;
         n = (bp >= BP_ALL_BLOCKS) ? BLOCK_COUNT : (UNIT_ONE << (bp - 3'h1));
      end
      hit = bottom ? (unit < n) : (unit >= (total - n));
      protFn = (bp != BP_NONE) && hit;
   endfunction

   logic [5:0] pinSync;
   logic csN;
   logic sclk;
   logic [3:0] lineIn;

   qsf_sync2 #(.WIDTH(6)) u_sync
   (
      .clock(clock),
      .rst_n(rst_n),
      .asyncIn({chipSelN, serialClk, dataLine3In, dataLine2In, dataLine1In, dataLine0In}),
      .syncOut(pinSync)
   );

   assign csN = pinSync[5];
   assign sclk = pinSync[4];
   assign lineIn = pinSync[3:0];

   qsf_link_type state_reg;
   qsf_link_type state_next;
   logic csPrev_reg;
   logic sclkPrev_reg;
   logic [3:0] bitCount_reg;
   logic [3:0] bitCount_next;
   logic [3:0] txCount_reg;
   logic [3:0] txCount_next;
   logic [7:0] rxShift_reg;
   logic [7:0] rxShift_next;
   logic [7:0] txShift_reg;
   logic [7:0] txShift_next;
   logic [8:0] progCount_reg;
   logic [8:0] progCount_next;
   logic [3:0] out_reg;
   logic [3:0] out_next;
   logic [3:0] oeN_reg;
   logic [3:0] oeN_next;
   logic selected_next;
   logic frameStart_next;
   logic frameEnd_next;
   logic holdActive_next;
   logic [7:0] rxData_next;
   logic rxValid_next;
   logic txTake_next;
   logic quadRefused_next;
   logic statusWriteAllowed_next;
   logic addrProtected_next;
   logic startsAtAddress_next;
   logic programOverflow_next;
   logic [7:0] idByte_next;

   logic csFall;
   logic sclkRise;
   logic sclkFall;
   logic wpEffN;
   logic laneBad;
   logic shifting;
   logic [3:0] step;
   logic [3:0] rxSum;
   logic [3:0] txSum;
   logic [7:0] word;
   logic [7:0] rxByte;

   always_comb
   begin
      csFall = csPrev_reg && !csN;
      sclkRise = !sclkPrev_reg && sclk;
      sclkFall = sclkPrev_reg && !sclk;
      wpEffN = quadEnableBit ? 1'b1 : lineIn[2];
      laneBad = (laneMode == LANE_QUAD) && !quadEnableBit;
      step = laneBits(laneMode);
      rxSum = bitCount_reg + step;
      txSum = txCount_reg + step;
      word = RESET_BYTE;
      rxByte = RESET_BYTE;

      state_next = state_reg;
      unique case (state_reg)
         LS_UNARMED:
            if (csFall)
               state_next = LS_ACTIVE;
         LS_IDLE:
            if (csFall)
               state_next = LS_ACTIVE;
         LS_ACTIVE:
            if (csN)
               state_next = LS_IDLE;
            else if (!quadEnableBit && !lineIn[3] && !sclk)
               state_next = LS_HOLD;
         LS_HOLD:
            if (csN)
               state_next = LS_IDLE;
            else if ((lineIn[3] || quadEnableBit) && !sclk)
               state_next = LS_ACTIVE;
         default:
            state_next = LS_UNARMED;
      endcase

      shifting = (state_reg == LS_ACTIVE) && !csN && !laneBad;
      bitCount_next = bitCount_reg;
      txCount_next = txCount_reg;
      rxShift_next = rxShift_reg;
      txShift_next = txShift_reg;
      progCount_next = progCount_reg;
      out_next = out_reg;
      rxData_next = rxData;
      rxValid_next = RESET_BIT;
      txTake_next = RESET_BIT;
      programOverflow_next = programOverflow;
      startsAtAddress_next = startsAtAddress;

      if (csFall && state_reg != LS_ACTIVE)
      begin
         bitCount_next = RESET_COUNT;
         txCount_next = RESET_COUNT;
         progCount_next = RESET_PROG;
         programOverflow_next = RESET_BIT;
         startsAtAddress_next = contReadMode;
      end

      if (shifting && sclkRise && !driveOut)
      begin
         unique case (laneMode)
            LANE_DUAL: rxByte = {rxShift_reg[5:0], lineIn[1], lineIn[0]};
            LANE_QUAD: rxByte = {rxShift_reg[3:0], lineIn[3:0]};
            default: rxByte = {rxShift_reg[6:0], lineIn[0]};
         endcase
         rxShift_next = rxByte;
         if (rxSum >= BITS_PER_BYTE)
         begin
            bitCount_next = RESET_COUNT;
            rxData_next = rxByte;
            rxValid_next = 1'b1;
            if (programPhase)
            begin
               if (progCount_reg == PROG_LIMIT)
                  programOverflow_next = 1'b1;
               else
                  progCount_next = progCount_reg + PROG_STEP;
            end
         end
         else
            bitCount_next = rxSum;
      end

      if (shifting && sclkFall && driveOut)
      begin
         if (txCount_reg == RESET_COUNT)
         begin
            word = txData;
            txTake_next = 1'b1;
         end
         else
            word = txShift_reg;
         unique case (laneMode)
            LANE_DUAL: out_next = {out_reg[3:2], word[7], word[6]};
            LANE_QUAD: out_next = word[7:4];
            default: out_next = {out_reg[3:2], word[7], out_reg[0]};
         endcase
         txShift_next = word << step;
         txCount_next = (txSum >= BITS_PER_BYTE) ? RESET_COUNT : txSum;
      end

      // drivers: line 1 in single, lines 0 and 1 in dual, all four in quad, nothing unless selected
      oeN_next = {4{RESET_OE_N}};
      if (state_next == LS_ACTIVE && !csN && driveOut && !laneBad)
      begin
         unique case (laneMode)
            LANE_DUAL: oeN_next = 4'hC;
            LANE_QUAD: oeN_next = 4'h0;
            default: oeN_next = 4'hD;
         endcase
      end

      selected_next = (state_next == LS_ACTIVE) || (state_next == LS_HOLD);
      frameStart_next = (state_next == LS_ACTIVE) && csFall && (state_reg != LS_ACTIVE);
      frameEnd_next = csN && ((state_reg == LS_ACTIVE) || (state_reg == LS_HOLD));
      holdActive_next = state_next == LS_HOLD;
      quadRefused_next = selected_next && laneBad;

      if (statusProtectBits[1])
         statusWriteAllowed_next = 1'b0;
      else if (statusProtectBits[0])
         statusWriteAllowed_next = wpEffN;
      else
         statusWriteAllowed_next = 1'b1;

      addrProtected_next = protFn(checkAddr, blockProtectBits, sectorSelectBit, topBottomBit);

      unique case (idByteSel)
         4'h0: idByte_next = MANUFACTURER_ID;
         4'h1: idByte_next = DEVICE_ID[15:8];
         4'h2: idByte_next = DEVICE_ID[7:0];
         4'h3: idByte_next = UNIQUE_ID[63:56];
         4'h4: idByte_next = UNIQUE_ID[55:48];
         4'h5: idByte_next = UNIQUE_ID[47:40];
         4'h6: idByte_next = UNIQUE_ID[39:32];
         4'h7: idByte_next = UNIQUE_ID[31:24];
         4'h8: idByte_next = UNIQUE_ID[23:16];
         4'h9: idByte_next = UNIQUE_ID[15:8];
         4'hA: idByte_next = UNIQUE_ID[7:0];
         default: idByte_next = RESET_BYTE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg <= LS_UNARMED;
         csPrev_reg <= RESET_BIT;
         sclkPrev_reg <= RESET_BIT;
         bitCount_reg <= RESET_COUNT;
         txCount_reg <= RESET_COUNT;
         rxShift_reg <= RESET_BYTE;
         txShift_reg <= RESET_BYTE;
         progCount_reg <= RESET_PROG;
         out_reg <= {4{RESET_BIT}};
         oeN_reg <= {4{RESET_OE_N}};
         selected <= RESET_BIT;
         frameStart <= RESET_BIT;
         frameEnd <= RESET_BIT;
         holdActive <= RESET_BIT;
         rxData <= RESET_BYTE;
         rxValid <= RESET_BIT;
         txTake <= RESET_BIT;
         quadRefused <= RESET_BIT;
         statusWriteAllowed <= RESET_BIT;
         addrProtected <= RESET_BIT;
         startsAtAddress <= RESET_BIT;
         programOverflow <= RESET_BIT;
         idByte <= RESET_BYTE;
      end
      else
      begin
         state_reg <= state_next;
         csPrev_reg <= csN;
         sclkPrev_reg <= sclk;
         bitCount_reg <= bitCount_next;
         txCount_reg <= txCount_next;
         rxShift_reg <= rxShift_next;
         txShift_reg <= txShift_next;
         progCount_reg <= progCount_next;
         out_reg <= out_next;
         oeN_reg <= oeN_next;
         selected <= selected_next;
         frameStart <= frameStart_next;
         frameEnd <= frameEnd_next;
         holdActive <= holdActive_next;
         rxData <= rxData_next;
         rxValid <= rxValid_next;
         txTake <= txTake_next;
         quadRefused <= quadRefused_next;
         statusWriteAllowed <= statusWriteAllowed_next;
         addrProtected <= addrProtected_next;
         startsAtAddress <= startsAtAddress_next;
         programOverflow <= programOverflow_next;
         idByte <= idByte_next;
      end
   end

   assign dataLine0Out = out_reg[0];
   assign dataLine1Out = out_reg[1];
   assign dataLine2Out = out_reg[2];
   assign dataLine3Out = out_reg[3];
   assign dataLine0OeN = oeN_reg[0];
   assign dataLine1OeN = oeN_reg[1];
   assign dataLine2OeN = oeN_reg[2];
   assign dataLine3OeN = oeN_reg[3];
endmodule
`default_nettype wire

/* sim/qsf_assertions.sv */
// port level checks of the flash pin interface
`timescale 1ns/1ps
`default_nettype none
module qsf_assertions
import qsf_pkg::*;
#(
   parameter logic [7:0] MANUFACTURER_ID = 8'h00,
   parameter logic [63:0] UNIQUE_ID = 64'h0
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire qsf_pkg::qsf_lane_type laneMode,
   input wire logic quadEnableBit,
   input wire logic [1:0] statusProtectBits,
   input wire logic [2:0] blockProtectBits,
   input wire logic sectorSelectBit,
   input wire logic [3:0] idByteSel,
   input wire logic dataLine0OeN,
   input wire logic dataLine1OeN,
   input wire logic dataLine2OeN,
   input wire logic dataLine3OeN,
   input wire logic selected,
   input wire logic frameStart,
   input wire logic holdActive,
   input wire logic quadRefused,
   input wire logic statusWriteAllowed,
   input wire logic addrProtected,
   input wire logic [7:0] idByte
);
   import qsf_pkg::*;
   logic allOff;
   assign allOff = dataLine0OeN & dataLine1OeN & dataLine2OeN & dataLine3OeN;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_idle_float: assert property (!selected && !$past(selected) |-> allOff)
      else $error("line driven while deselected");
   a_select_follow: assert property (frameStart |-> ##[0:1] selected)
      else $error("frame start without selection");
   a_quad_refused: assert property (quadRefused && $past(quadRefused) |-> allOff)
      else $error("refused quad transfer drives lines");
   a_hold_float: assert property (holdActive && $past(holdActive) |-> allOff)
      else $error("line driven during hold");
   a_narrow_lanes: assert property (laneMode != LANE_QUAD && $past(laneMode) != LANE_QUAD
      |-> dataLine2OeN && dataLine3OeN)
      else $error("upper lines driven outside quad");
   a_status_lock: assert property (statusProtectBits[1] |=> !statusWriteAllowed)
      else $error("status write allowed while locked");
   a_status_open: assert property (statusProtectBits == 2'h0 |=> statusWriteAllowed)
      else $error("status write refused while unprotected");
   a_quad_protect_off: assert property (statusProtectBits == 2'h1 && quadEnableBit
      |=> statusWriteAllowed)
      else $error("write protect pin active in quad");
   a_prot_none: assert property (blockProtectBits == 3'h0 |=> !addrProtected)
      else $error("address protected with no protect bits");
   a_prot_all: assert property (!sectorSelectBit && blockProtectBits >= 3'h6
      |=> addrProtected)
      else $error("address writable under full protection");
   a_id_maker: assert property (idByteSel == 4'h0 |=> idByte == MANUFACTURER_ID)
      else $error("manufacturer byte wrong");
   a_id_serial: assert property (idByteSel == 4'h3 |=> idByte == UNIQUE_ID[63:56])
      else $error("first serial number byte wrong");
endmodule
`default_nettype wire

/* sim/qsf_host_model.sv */
// behavioural spi host that clocks frames into the flash pin interface
`timescale 1ns/1ps
`default_nettype none
module qsf_host_model
(
   output logic chipSelN,
   output logic serialClk,
   output logic [3:0] pins,
   input wire logic [3:0] devOut,
   input wire logic [3:0] devOeN
);
   logic [3:0] drv = 4'hF;
   logic [3:0] val = 4'hF;
   logic [3:0] last;
   logic cpol = 1'b0;
   initial chipSelN = 1'b0;
   initial serialClk = 1'b0;
   initial last = 4'h0;
   // released lines show the inverse of what they last carried
   always @(serialClk) last <= pins;
   always_comb
      for (int i = 0; i < 4; i++)
         pins[i] = !devOeN[i] ? devOut[i] : drv[i] ? val[i] : ~last[i];
   task automatic sel(input logic lvl);
      serialClk = cpol;
      #100;
      chipSelN = lvl;
      #100;
   endtask
   task automatic setPins23(input logic wpN, input logic holdN);
      drv[3:2] = 2'h3;
      val[3:2] = {holdN, wpN};
   endtask
   task automatic shift(input int w, input logic [7:0] wr, input logic rd,
      output logic [7:0] got);
      logic [7:0] b;
      logic [3:0] m;
      got = 8'h00;
      m = 4'((1 << w) - 1);
      for (int g = 0; g < 8 / w; g++)
      begin
         serialClk = 1'b0;
         b = wr << (g * w);
         drv = rd ? (w == 4 ? 4'h0 : 4'hC) : (w == 4 ? 4'hF : 4'hC | m);
         val = w == 4 ? 4'(b >> 4) : {val[3:2], 2'(b >> (8 - w))};
         #62.5;
         got = 8'((got << w) | (w == 1 ? 4'(pins[1]) : pins & m));
         serialClk = 1'b1;
         #62.5;
      end
   endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the flash pin interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import qsf_pkg::*;
   localparam logic [7:0] MFR_ID = 8'hA7; // arbitrary value
   localparam logic [15:0] DEV_ID = 16'h1B2C; // arbitrary value
   localparam logic [63:0] UID = 64'h1122334455667788; // arbitrary value
   localparam int CHIP = PAGE_BYTES * PAGE_COUNT;
   logic clock, rst_n, chipSelN, serialClk, quadEnableBit, sectorSelectBit, topBottomBit;
   logic driveOut, contReadMode, programPhase, skipRx, wpLvl;
   logic [3:0] pins, devOut, devOeN, idByteSel;
   logic [1:0] statusProtectBits;
   logic [2:0] blockProtectBits;
   logic [7:0] txData, rxData, idByte, got, b;
   logic [20:0] checkAddr;
   qsf_lane_type laneMode;
   logic selected, frameStart, frameEnd, holdActive, rxValid, txTake, quadRefused;
   logic statusWriteAllowed, addrProtected, startsAtAddress, programOverflow;
   logic [7:0] expQ[$];
   int n_mismatch = 0;
   int n_checks = 0;
   int nTake = 0;
   int nEnd = 0;
   int seed = 32'hE9AF713F;
   qsf_pin_if #(.MANUFACTURER_ID(MFR_ID), .DEVICE_ID(DEV_ID), .UNIQUE_ID(UID)) DUT (.*,
      .dataLine0In(pins[0]), .dataLine1In(pins[1]), .dataLine2In(pins[2]),
      .dataLine3In(pins[3]), .dataLine0Out(devOut[0]), .dataLine1Out(devOut[1]),
      .dataLine2Out(devOut[2]), .dataLine3Out(devOut[3]), .dataLine0OeN(devOeN[0]),
      .dataLine1OeN(devOeN[1]), .dataLine2OeN(devOeN[2]), .dataLine3OeN(devOeN[3]));
   qsf_host_model host (.chipSelN, .serialClk, .pins, .devOut, .devOeN);
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic frame(input logic cr);
      cyc(1);
      contReadMode = cr;
      host.sel(1'b1);
      host.sel(1'b0);
      cyc(1);
   endtask
   task automatic drop();
      host.sel(1'b1);
      host.setPins23(1'b1, 1'b1);
      cyc(1);
   endtask
   task automatic wr(input int w);
      b = 8'($random(seed));
      expQ.push_back(b);
      host.shift(w, b, 1'b0, got);
   endtask
   task automatic rd(input int w);
      cyc(1);
      txData = 8'($random(seed));
      driveOut = 1'b1;
      host.shift(w, 8'h00, 1'b1, got);
      check("readByte", txData, got);
      cyc(1);
      driveOut = 1'b0;
   endtask
   function automatic logic expSw();
      if (statusProtectBits[1])
         return 1'b0;
      return statusProtectBits[0] ? quadEnableBit | wpLvl : 1'b1;
   endfunction
   function automatic logic expProt();
      int sz;
      int n;
      n = int'(blockProtectBits);
      if (n == 0)
         return 1'b0;
      if (sectorSelectBit)
         sz = (PAGE_BYTES * SECTOR_PAGES) << ((n > 4 ? 4 : n) - 1);
      else
         sz = n >= 6 ? CHIP : (PAGE_BYTES * BLOCK64_PAGES) << (n - 1);
      return topBottomBit ? int'(checkAddr) < sz : int'(checkAddr) >= CHIP - sz;
   endfunction
   function automatic logic [7:0] expId();
      if (idByteSel == 4'h0)
         return MFR_ID;
      if (idByteSel < 4'h3)
         return idByteSel == 4'h1 ? DEV_ID[15:8] : DEV_ID[7:0];
      return idByteSel <= 4'hA ? UID[8 * (10 - idByteSel) +: 8] : 8'h00;
   endfunction
   always @(negedge clock)
      if (rst_n && rxValid === 1'b1 && !skipRx)
      begin
         if (expQ.size() == 0)
            check("rxValid", 8'h00, 8'h01);
         else
            check("rxData", expQ.pop_front(), rxData);
      end
   // count byte takes and frame ends
   always @(negedge clock)
   begin
      nTake += int'(txTake === 1'b1);
      nEnd += int'(frameEnd === 1'b1);
   end
   initial
   begin
      #300000;
      n_mismatch++;
      stop_test();
   end
   initial
   begin
      rst_n = 1'b0;
      laneMode = LANE_SINGLE;
      {driveOut, txData, quadEnableBit, statusProtectBits, blockProtectBits} = '0;
      {sectorSelectBit, topBottomBit, contReadMode, programPhase, checkAddr} = '0;
      {idByteSel, skipRx, wpLvl} = '0;
      cyc(6);
      rst_n = 1'b1;
      host.shift(1, 8'h5A, 1'b0, got);
      cyc(1);
      check("selected", 8'h00, selected);
      for (int m = 0; m < 2; m++)
         for (int ln = 0; ln < 3; ln++)
         begin
            host.cpol = m[0];
            cyc(1);
            quadEnableBit = 1'b1;
            laneMode = qsf_lane_type'(ln);
            frame(1'b0);
            check("selected", 8'h01, selected);
            wr(1 << ln);
            rd(1 << ln);
            wr(1 << ln);
            drop();
            check("outEnN", 8'h0F, devOeN);
            check("rxLeft", 8'h00, 8'(expQ.size()));
         end
      cyc(1);
      quadEnableBit = 1'b0;
      laneMode = LANE_QUAD;
      frame(1'b0);
      host.shift(4, 8'hCC, 1'b0, got);
      cyc(1);
      check("quadRefused", 8'h01, quadRefused);
      drop();
      laneMode = LANE_SINGLE;
      host.cpol = 1'b0;
      frame(1'b0);
      host.setPins23(1'b1, 1'b0);
      cyc(4);
      check("holdActive", 8'h01, holdActive);
      driveOut = 1'b1;
      host.shift(1, 8'h96, 1'b0, got);
      check("outEnN1", 8'h01, devOeN[1]);
      cyc(1);
      driveOut = 1'b0;
      host.shift(1, 8'h69, 1'b0, got);
      host.serialClk = 1'b0;
      cyc(1);
      host.setPins23(1'b1, 1'b1);
      cyc(4);
      check("holdActive", 8'h00, holdActive);
      wr(1);
      drop();
      quadEnableBit = 1'b1;
      laneMode = LANE_QUAD;
      programPhase = 1'b1;
      frame(1'b1);
      contReadMode = 1'b0;
      check("startsAtAddress", 8'h01, startsAtAddress);
      repeat (256) wr(4);
      cyc(1);
      check("programOverflow", 8'h00, programOverflow);
      skipRx = 1'b1;
      host.shift(4, 8'h33, 1'b0, got);
      cyc(4);
      check("programOverflow", 8'h01, programOverflow);
      drop();
      skipRx = 1'b0;
      frame(1'b0);
      check("startsAtAddress", 8'h00, startsAtAddress);
      drop();
      check("txTake", 8'h06, 8'(nTake));
      check("frameEnd", 8'h0A, 8'(nEnd));
      for (int i = 0; i < 64; i++)
      begin
         cyc(1);
         {quadEnableBit, statusProtectBits, blockProtectBits, sectorSelectBit, topBottomBit} =
            7'($random(seed));
         checkAddr = 21'($random(seed));
         idByteSel = 4'(i);
         wpLvl = 1'($random(seed));
         host.setPins23(wpLvl, 1'b1);
         cyc(5);
         check("statusWriteAllowed", 8'(expSw()), statusWriteAllowed);
         check("addrProtected", 8'(expProt()), addrProtected);
         check("idByte", expId(), idByte);
      end
      stop_test();
   end
endmodule
bind qsf_pin_if qsf_assertions #(.MANUFACTURER_ID(MANUFACTURER_ID), .UNIQUE_ID(UNIQUE_ID))
   chk (.*);
`default_nettype wire
